/* common/seq_pkg.sv */
// constants and types for the instruction cycle sequencer
package seq_pkg;

  typedef enum logic [2:0] {CYC_NONE, CYC_READ, CYC_WRITE, CYC_ALU, CYC_SERIAL_IO, CYC_SRC_ACQ} cyc_t;

  typedef enum logic [3:0] {
    PROG_UNSIGNED_MULTIPLY, PROG_SIGNED_MULTIPLY, PROG_NEGATE_OP, PROG_XOR, PROG_SET_ALL_ONES,
    PROG_SHIFT_REG_COUNT, PROG_SHIFT_IMM, PROG_SERIAL_FIELD_STORE, PROG_EXTENDED_OPERATION, PROG_HW_RESET
  } prog_t;

  typedef enum logic {ST_IDLE, ST_RUN} state_t;

  // step codes, one nibble each, step 0 in the low nibble of a program word
  localparam logic [3:0] STEP_END    = 4'h0;
  localparam logic [3:0] STEP_READ   = 4'h1;
  localparam logic [3:0] STEP_WRITE  = 4'h2;
  localparam logic [3:0] STEP_ALU    = 4'h3;
  localparam logic [3:0] STEP_SRC    = 4'h4;
  localparam logic [3:0] STEP_ALU16  = 4'h5;
  localparam logic [3:0] STEP_ALU15  = 4'h6;
  localparam logic [3:0] STEP_SHIFT  = 4'h7;
  localparam logic [3:0] STEP_SERIAL = 4'h8;

  localparam int         PROG_COUNT  = 10;
  localparam logic [4:0] LAST_SLOT   = 5'h0F;

  localparam logic [63:0] PROG_TABLE [PROG_COUNT] = '{
    64'h0000_2332_5331_1431,  // unsigned multiply
    64'h0233_3236_3133_1431,  // signed multiply
    64'h0000_0000_0233_1431,  // negate
    64'h0000_0000_0231_1431,  // exclusive-or
    64'h0000_0000_0002_3431,  // set all ones
    64'h0000_0327_3313_3131,  // shift, count from register zero
    64'h0000_0000_0327_3131,  // shift, immediate count
    64'h0023_3338_3133_1431,  // serial field store
    64'h0312_3232_3231_3431,  // extended operation
    64'h0000_0312_3232_3133   // hardware reset
  };

  localparam logic [4:0] REP_ONE       = 5'h01;
  localparam logic [4:0] REP_FULL      = 5'h10;
  localparam logic [4:0] REP_SIGNED    = 5'h0F;
  localparam logic [4:0] REP_HALF      = 5'h08;
  localparam logic [3:0] SERIAL_SHORT  = 4'h8;
  localparam logic [3:0] COUNT_ZERO    = 4'h0;
  localparam int         COUNT_MSB     = 15;
  localparam int         COUNT_LSB     = 12;
  localparam logic [5:0] TALLY_START   = 6'h01;

endpackage

/* common/step_if.sv */
// lookup link between the sequencer and its program store
`timescale 1ns/1ps
interface step_if;
  import seq_pkg::*;
  prog_t      prog;
  logic [3:0] base;
  logic [3:0] code0;
  logic [3:0] code1;
  logic [3:0] code2;
  modport seqr (output prog, base, input code0, code1, code2);
  modport store (input prog, base, output code0, code1, code2);
endinterface

/* hdl/cycle_sequencer.sv */
// machine-cycle sequencer: issues typed cycles for each instruction program
`timescale 1ns/1ps
module cycle_sequencer
  import seq_pkg::*;
#(
  parameter int ACQ_W = 4
)(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire prog_t            start_prog,
  input  wire logic [3:0]       imm_count,
  input  wire logic [15:0]      workspace_reg_zero,
  input  wire logic [3:0]       serial_bit_count,
  input  wire logic [ACQ_W-1:0] source_fetch_cycles,
  output cyc_t                  cyc_type,
  output logic                  busy,
  output logic                  seq_done
);

  generate
    if (ACQ_W < 1 || ACQ_W > 4) begin : g_bad_width
      $error("ACQ_W must lie between 1 and 4");
    end
  endgenerate

  step_if sl ();

  step_rom u_rom (
    .sl (sl)
  );

  state_t     state;
  prog_t      prog;
  logic [3:0] idx;
  logic [4:0] remain;
  logic [4:0] ns_reg;
  logic [3:0] cnt_reg;
  logic [4:0] nser_reg;
  logic [5:0] tally;

  state_t     next_state;
  prog_t      next_prog;
  logic [3:0] next_idx;
  logic [4:0] next_remain;
  logic [4:0] next_ns;
  logic [3:0] next_cnt;
  logic [4:0] next_nser;
  logic [5:0] next_tally;
  cyc_t       next_cyc;
  logic       next_busy;
  logic       next_done;

  logic       adv;
  logic [3:0] adv_idx;
  logic [3:0] adv_code;
  prog_t      pick;

  function automatic cyc_t kind_of(input logic [3:0] code);
    unique case (code)
      STEP_READ:   kind_of = CYC_READ;
      STEP_WRITE:  kind_of = CYC_WRITE;
      STEP_SERIAL: kind_of = CYC_SERIAL_IO;
      STEP_SRC:    kind_of = CYC_SRC_ACQ;
      STEP_END:    kind_of = CYC_NONE;
      default:     kind_of = CYC_ALU;
    endcase
  endfunction

  // shift count: a nonzero immediate wins, else register zero is read live as the loop begins
  function automatic logic [4:0] shift_reps(input logic [3:0] imm, input logic [3:0] reg_field);
    if (imm != COUNT_ZERO) begin
      shift_reps = {1'b0, imm};
    end else if (reg_field == COUNT_ZERO) begin
      shift_reps = REP_FULL;
    end else begin
      shift_reps = {1'b0, reg_field};
    end
  endfunction

  function automatic logic [4:0] reps_of(input logic [3:0] code, input logic [4:0] ns,
                                         input logic [3:0] imm, input logic [4:0] nser);
    unique case (code)
      STEP_SRC:    reps_of = ns;
      STEP_ALU16:  reps_of = REP_FULL;
      STEP_ALU15:  reps_of = REP_SIGNED;
      STEP_SHIFT:  reps_of = shift_reps(imm, workspace_reg_zero[COUNT_MSB:COUNT_LSB]);
      STEP_SERIAL: reps_of = nser;
      default:     reps_of = REP_ONE;
    endcase
  endfunction

  // a shift asked with a zero immediate takes the longer program that fetches register zero
  assign pick = (start_prog == PROG_SHIFT_IMM && imm_count == COUNT_ZERO) ? PROG_SHIFT_REG_COUNT : start_prog;

  // while idle the store looks at the program about to start, so step 0 is ready on the start edge
  assign sl.prog = (state == ST_IDLE) ? pick : prog;
  assign sl.base = (state == ST_IDLE) ? 4'h0 : idx;

  always_comb begin
    next_state  = state;
    next_prog   = prog;
    next_idx    = idx;
    next_remain = remain;
    next_ns     = ns_reg;
    next_cnt    = cnt_reg;
    next_nser   = nser_reg;
    next_cyc    = cyc_type;
    next_busy   = busy;
    next_done   = 1'b0;
    next_tally  = busy ? tally + 6'h01 : tally;
    adv         = 1'b0;
    adv_idx     = idx;
    adv_code    = STEP_END;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_RUN;
          next_prog  = pick;
          next_ns    = 5'(source_fetch_cycles);
          next_cnt   = imm_count;
          next_nser  = (serial_bit_count == COUNT_ZERO || serial_bit_count > SERIAL_SHORT) ? REP_FULL : REP_HALF;
          next_tally = TALLY_START;
          adv        = 1'b1;
          adv_idx    = 4'h0;
          adv_code   = sl.code0;
        end
      end
      ST_RUN: begin
        if (remain > REP_ONE) begin
          next_remain = remain - REP_ONE;
        end else if (sl.code1 == STEP_END) begin
          // last cycle of the program has been issued
          next_state = ST_IDLE;
          next_cyc   = CYC_NONE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
        end else if (sl.code1 == STEP_SRC && ns_reg == 5'h00) begin
          // no acquisition cycles: skip the slot without losing a clock
          adv      = 1'b1;
          adv_idx  = idx + 4'h2;
          adv_code = sl.code2;
        end else begin
          adv      = 1'b1;
          adv_idx  = idx + 4'h1;
          adv_code = sl.code1;
        end
      end
    endcase
    if (adv) begin
      next_idx    = adv_idx;
      next_remain = reps_of(adv_code, next_ns, next_cnt, next_nser);
      next_cyc    = kind_of(adv_code);
      next_busy   = 1'b1;
    end
  end

  // leaving reset the hardware reset program is already on its first cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_RUN;
      prog     <= PROG_HW_RESET;
      idx      <= 4'h0;
      remain   <= REP_ONE;
      ns_reg   <= 5'h00;
      cnt_reg  <= COUNT_ZERO;
      nser_reg <= REP_FULL;
      tally    <= TALLY_START;
      cyc_type <= CYC_ALU;
      busy     <= 1'b1;
      seq_done <= 1'b0;
    end else begin
      state    <= next_state;
      prog     <= next_prog;
      idx      <= next_idx;
      remain   <= next_remain;
      ns_reg   <= next_ns;
      cnt_reg  <= next_cnt;
      nser_reg <= next_nser;
      tally    <= next_tally;
      cyc_type <= next_cyc;
      busy     <= next_busy;
      seq_done <= next_done;
    end
  end

  // tally numbers the current cycle from 1; at seq_done it is the program length plus one

  AST_UMPY_ITER: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy && prog == PROG_UNSIGNED_MULTIPLY && tally == 6'(ns_reg) + 6'd7 |-> (cyc_type == CYC_ALU) [*8])
    else $error("unsigned multiply iterations not ALU");

  AST_UMPY_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_UNSIGNED_MULTIPLY |-> tally == 6'(ns_reg) + 6'd27 && $past(cyc_type) == CYC_WRITE)
    else $error("unsigned multiply length or last cycle wrong");

  AST_SMPY_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_SIGNED_MULTIPLY |-> tally == 6'(ns_reg) + 6'd29 && $past(cyc_type) == CYC_WRITE)
    else $error("signed multiply length wrong");

  AST_NEG_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_NEGATE_OP |-> tally == 6'(ns_reg) + 6'd7 && $past(cyc_type, 2) == CYC_ALU)
    else $error("negate length wrong");

  AST_XOR_READS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy && prog == PROG_XOR && tally == 6'(ns_reg) + 6'd3 |-> cyc_type == CYC_READ ##1 cyc_type == CYC_READ
      ##1 cyc_type == CYC_ALU ##1 cyc_type == CYC_WRITE ##1 seq_done)
    else $error("exclusive-or order wrong");

  AST_RESET_LEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_HW_RESET |-> tally == 6'd12 && $past(cyc_type, 2) == CYC_READ)
    else $error("reset sequence length wrong");

  AST_SET_ALL_ONES_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_SET_ALL_ONES |-> tally == 6'(ns_reg) + 6'd5)
    else $error("set all ones length wrong");

  AST_SHIFT_IMM_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_SHIFT_IMM |-> tally == 6'(cnt_reg) + 6'd7 && $past(cyc_type, 2) == CYC_WRITE)
    else $error("immediate shift length wrong");

  AST_SHIFT_REG_TAIL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_SHIFT_REG_COUNT |-> $past(cyc_type, 2) == CYC_WRITE && $past(cyc_type) == CYC_ALU
      && tally > 6'd11 && tally < 6'd28)
    else $error("register-count shift tail wrong");

  AST_STORE_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_SERIAL_FIELD_STORE |-> tally == 6'(ns_reg) + 6'(nser_reg) + 6'd13)
    else $error("serial field store length wrong");

  AST_XOP_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_done && prog == PROG_EXTENDED_OPERATION |-> tally == 6'(ns_reg) + 6'd15)
    else $error("extended operation length wrong");

  AST_SRC_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy && tally == 6'd3 && ns_reg != 5'h00 && prog inside {PROG_UNSIGNED_MULTIPLY, PROG_NEGATE_OP, PROG_XOR}
      |-> cyc_type == CYC_SRC_ACQ)
    else $error("acquisition cycles not inserted");

  AST_TAGGED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy == (cyc_type != CYC_NONE))
    else $error("cycle tag and busy disagree");

endmodule

/* hdl/step_rom.sv */
// program store: step codes at base, base+1 and base+2
`timescale 1ns/1ps
module step_rom
  import seq_pkg::*;
(
  step_if.store sl
);

  function automatic logic [3:0] code_at(input prog_t p, input logic [4:0] i);
    logic [63:0] w;
    w = PROG_TABLE[p];
    code_at = (i > LAST_SLOT) ? STEP_END : w[{i[3:0], 2'b00} +: 4];
  endfunction

  assign sl.code0 = code_at(sl.prog, {1'b0, sl.base});
  assign sl.code1 = code_at(sl.prog, {1'b0, sl.base} + 5'h01);
  assign sl.code2 = code_at(sl.prog, {1'b0, sl.base} + 5'h02);

endmodule

/* tb/bus_partner.sv */
// far-side bus model: logs every machine cycle the sequencer issues
`timescale 1ns/1ps
module bus_partner
  import seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire cyc_t cyc_type,
  input wire logic busy
);
  cyc_t log_q[$];
  // no hold state is modelled here, so no exit wait state is ever inserted
  always @(posedge clk_sys) begin
    if (rst_b && busy) begin
      log_q.push_back(cyc_type);
    end
  end
endmodule

/* tb/cycle_sequencer_tb_top.sv */
// self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module cycle_sequencer_tb_top;
  import seq_pkg::*;
  logic        clk_sys             = 1'b0;
  logic        rst_b               = 1'b0;
  logic        start               = 1'b0;
  prog_t       start_prog          = PROG_NEGATE_OP;
  logic [3:0]  imm_count           = 4'h0;
  logic [15:0] workspace_reg_zero  = 16'h0000;
  logic [3:0]  serial_bit_count    = 4'h0;
  logic [3:0]  source_fetch_cycles = 4'h0;
  cyc_t        cyc_type;
  logic        busy;
  logic        seq_done;
  int          err_count           = 0;
  int          compares            = 0;
  cyc_t        exp_q[$];

  always #5 clk_sys = ~clk_sys;

  cycle_sequencer #(.ACQ_W(4)) dut (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .start               (start),
    .start_prog          (start_prog),
    .imm_count           (imm_count),
    .workspace_reg_zero  (workspace_reg_zero),
    .serial_bit_count    (serial_bit_count),
    .source_fetch_cycles (source_fetch_cycles),
    .cyc_type            (cyc_type),
    .busy                (busy),
    .seq_done            (seq_done)
  );

  bus_partner bus (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .cyc_type (cyc_type),
    .busy     (busy)
  );

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic add(input cyc_t c, input int n);
    repeat (n) exp_q.push_back(c);
  endtask

  // waits for the done pulse, then compares the logged cycles with the expectation
  task automatic finish_prog();
    int n;
    n = 0;
    while (seq_done !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(seq_done === 1'b1, "done seen");
    check(busy === 1'b0 && cyc_type === CYC_NONE, "idle at done");
    check(bus.log_q.size() == exp_q.size(), "cycle count");
    for (int i = 0; i < exp_q.size() && i < bus.log_q.size(); i++) begin
      check(bus.log_q[i] === exp_q[i], $sformatf("cycle %0d type", i + 1));
    end
    @(negedge clk_sys);
    check(seq_done === 1'b0, "done lasts one cycle");
    exp_q.delete();
  endtask

  // poke raises a second start mid-run, which must be ignored
  task automatic go(input prog_t p, input logic [3:0] imm, input logic [3:0] bits, input logic [3:0] ns,
                    input bit poke);
    @(negedge clk_sys);
    bus.log_q.delete();
    start = 1'b1;
    start_prog = p;
    imm_count = imm;
    serial_bit_count = bits;
    source_fetch_cycles = ns;
    @(negedge clk_sys);
    start = 1'b0;
    check(busy === 1'b1, "start taken");
    if (poke) begin
      repeat (2) @(negedge clk_sys);
      start = 1'b1;
      start_prog = PROG_HW_RESET;
      @(negedge clk_sys);
      start = 1'b0;
    end
    finish_prog();
  endtask

  task automatic head(input logic [3:0] ns);
    add(CYC_READ, 1);
    add(CYC_ALU, 1);
    add(CYC_SRC_ACQ, ns);
  endtask

  task automatic t_reset();
    add(CYC_ALU, 2);
    add(CYC_READ, 1);
    for (int i = 0; i < 3; i++) begin
      add(CYC_ALU, 1);
      add(CYC_WRITE, 1);
    end
    add(CYC_READ, 1);
    add(CYC_ALU, 1);
    finish_prog();
  endtask

  task automatic t_umul(input logic [3:0] ns);
    head(ns);
    add(CYC_READ, 2);
    add(CYC_ALU, 18);
    add(CYC_WRITE, 1);
    add(CYC_ALU, 2);
    add(CYC_WRITE, 1);
    go(PROG_UNSIGNED_MULTIPLY, 4'h0, 4'h0, ns, 1'b0);
  endtask

  task automatic t_smul(input logic [3:0] ns);
    head(ns);
    add(CYC_READ, 1);
    add(CYC_ALU, 2);
    add(CYC_READ, 1);
    add(CYC_ALU, 17);
    add(CYC_WRITE, 1);
    add(CYC_ALU, 3);
    add(CYC_WRITE, 1);
    go(PROG_SIGNED_MULTIPLY, 4'h0, 4'h0, ns, 1'b0);
  endtask

  task automatic t_neg(input logic [3:0] ns);
    head(ns);
    add(CYC_READ, 1);
    add(CYC_ALU, 2);
    add(CYC_WRITE, 1);
    go(PROG_NEGATE_OP, 4'h0, 4'h0, ns, 1'b1);
  endtask

  task automatic t_xor(input logic [3:0] ns);
    head(ns);
    add(CYC_READ, 2);
    add(CYC_ALU, 1);
    add(CYC_WRITE, 1);
    go(PROG_XOR, 4'h0, 4'h0, ns, 1'b0);
  endtask

  task automatic t_set_all_ones(input logic [3:0] ns);
    head(ns);
    add(CYC_ALU, 1);
    add(CYC_WRITE, 1);
    go(PROG_SET_ALL_ONES, 4'h0, 4'h0, ns, 1'b0);
  endtask

  // zero in the count field stands for sixteen shifts
  task automatic t_shift_reg(input logic [3:0] nib, input prog_t p);
    workspace_reg_zero = {nib, 12'hA5A};
    head(4'h0);
    add(CYC_READ, 1);
    add(CYC_ALU, 2);
    add(CYC_READ, 1);
    add(CYC_ALU, 2 + ((nib == 4'h0) ? 16 : int'(nib)));
    add(CYC_WRITE, 1);
    add(CYC_ALU, 1);
    go(p, 4'h0, 4'h0, 4'h3, 1'b0);
  endtask

  task automatic t_shift_imm(input logic [3:0] c);
    head(4'h0);
    add(CYC_READ, 1);
    add(CYC_ALU, 1 + int'(c));
    add(CYC_WRITE, 1);
    add(CYC_ALU, 1);
    go(PROG_SHIFT_IMM, c, 4'h0, 4'h2, 1'b0);
  endtask

  task automatic t_serial(input logic [3:0] bits, input logic [3:0] ns);
    head(ns);
    add(CYC_READ, 1);
    add(CYC_ALU, 2);
    add(CYC_READ, 1);
    add(CYC_ALU, 1);
    add(CYC_SERIAL_IO, (bits >= 4'h1 && bits <= 4'h8) ? 8 : 16);
    add(CYC_ALU, 4);
    add(CYC_WRITE, 1);
    go(PROG_SERIAL_FIELD_STORE, 4'h0, bits, ns, 1'b0);
  endtask

  task automatic t_xop(input logic [3:0] ns);
    head(ns);
    add(CYC_ALU, 1);
    add(CYC_READ, 1);
    for (int i = 0; i < 4; i++) begin
      add(CYC_ALU, 1);
      add(CYC_WRITE, 1);
    end
    add(CYC_READ, 1);
    add(CYC_ALU, 1);
    go(PROG_EXTENDED_OPERATION, 4'h0, 4'h0, ns, 1'b0);
  endtask

  // a reset in mid-run abandons the program and restarts the reset sequence
  task automatic t_midreset();
    @(negedge clk_sys);
    start = 1'b1;
    start_prog = PROG_XOR;
    source_fetch_cycles = 4'h2;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b0;
    @(negedge clk_sys);
    check(busy === 1'b1 && cyc_type === CYC_ALU && seq_done === 1'b0, "state in reset");
    @(negedge clk_sys);
    bus.log_q.delete();
    rst_b = 1'b1;
    t_reset();
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_umul(4'h3);
    t_umul(4'h0);
    t_smul(4'h1);
    t_neg(4'h2);
    t_xor(4'h1);
    t_set_all_ones(4'h4);
    t_shift_reg(4'h0, PROG_SHIFT_IMM);
    t_shift_reg(4'h5, PROG_SHIFT_IMM);
    t_shift_reg(4'hF, PROG_SHIFT_REG_COUNT);
    t_shift_imm(4'h1);
    t_shift_imm(4'hF);
    t_serial(4'h0, 4'h1);
    t_serial(4'h1, 4'h0);
    t_serial(4'h8, 4'h2);
    t_serial(4'h9, 4'h0);
    t_serial(4'hF, 4'h0);
    t_xop(4'h2);
    t_midreset();
    give_verdict();
  end
endmodule
